// file: hdl/cadf_decoder.sv
// Instruction decoder with operand address generation and status word flags.
// Assumes all inputs come from core logic on clk_i; no pins reach it directly.
`timescale 1ns/1ps
`include "cadf_defines.svh"

module cadf_decoder (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic instr_valid_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] operand1_i,
	input wire logic [7:0] operand2_i,
	input wire logic [7:0] acc_i,
	input wire logic [15:0] data_pointer_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0] stack_pointer_i,
	input wire logic [7:0] working_register_0_i,
	input wire logic [7:0] working_register_1_i,
	input wire cadf_pkg::cadf_alu_flags_t alu_flags_i,
	input wire cadf_pkg::cadf_sfr_wr_t sfr_wr_i,
	output cadf_pkg::cadf_decode_t dec_o,
	output cadf_pkg::cadf_addr_t addr_o,
	output logic [7:0] program_status_word_o
);

	function automatic logic [1:0] instr_len(input logic [7:0] op);
		logic [1:0] l;
		l = 2'h1;
		case (op[3:0])
			4'h0: l = (op inside {8'h10, 8'h20, 8'h30, 8'h90}) ? 2'h3 :
				(op inside {8'h00, 8'hE0, 8'hF0}) ? 2'h1 : 2'h2;
			4'h1: l = 2'h2;
			4'h2: l = (op inside {8'h02, 8'h12}) ? 2'h3 :
				(op inside {8'h22, 8'h32, 8'hE2, 8'hF2}) ? 2'h1 : 2'h2;
			4'h3: l = (op inside {8'h43, 8'h53, 8'h63}) ? 2'h3 : 2'h1;
			4'h4: l = (op == 8'hB4) ? 2'h3 :
				(op inside {8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94}) ? 2'h2 : 2'h1;
			4'h5: l = (op inside {8'h75, 8'h85, 8'hB5, 8'hD5}) ? 2'h3 :
				(op == 8'hA5) ? 2'h1 : 2'h2;
			4'h6, 4'h7: l = (op[7:4] == 4'hB) ? 2'h3 :
				(op[7:4] inside {4'h7, 4'h8, 4'hA}) ? 2'h2 : 2'h1;
			default: l = (op[7:4] == 4'hB) ? 2'h3 :
				(op[7:4] inside {4'h7, 4'h8, 4'hA, 4'hD}) ? 2'h2 : 2'h1;
		endcase
		return l;
	endfunction

	function automatic cadf_pkg::cadf_mode_t operand_mode(input logic [3:0] lo);
		cadf_pkg::cadf_mode_t m;
		m = cadf_pkg::CADF_AM_REG;
		case (lo)
			4'h4: m = cadf_pkg::CADF_AM_IMMEDIATE;
			4'h5: m = cadf_pkg::CADF_AM_DIRECT;
			4'h6, 4'h7: m = cadf_pkg::CADF_AM_INDIRECT;
			default: m = cadf_pkg::CADF_AM_REG;
		endcase
		return m;
	endfunction

	function automatic cadf_pkg::cadf_flag_act_t flag_action(input logic [7:0] op);
		cadf_pkg::cadf_flag_act_t f;
		f = cadf_pkg::CADF_FL_NONE;
		if ((op[7:4] inside {4'h2, 4'h3, 4'h9}) && (op[3:0] >= 4'h4))
			f = cadf_pkg::CADF_FL_ARITH;
		else if (op == `CADF_OP_MUL || op == `CADF_OP_DIV)
			f = cadf_pkg::CADF_FL_MULDIV;
		else if (op == `CADF_OP_DEC_ADJ)
			f = cadf_pkg::CADF_FL_DEC_ADJ;
		else if (op == `CADF_OP_SET_C)
			f = cadf_pkg::CADF_FL_SET_C;
		else if (op == `CADF_OP_CLR_C)
			f = cadf_pkg::CADF_FL_CLR_C;
		else if ((op inside {8'h13, 8'h33, 8'hB3, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2}) ||
			(op[7:4] == 4'hB && op[3:0] >= 4'h4))
			f = cadf_pkg::CADF_FL_CARRY;
		return f;
	endfunction

	cadf_pkg::cadf_decode_t dec_r, dec_nxt;
	cadf_pkg::cadf_addr_t addr_r, addr_nxt;
	logic [7:0] stat_r, stat_nxt;
	logic [7:0] ri_val;
	logic stat_bit_hit;

	// Decode group
	always_comb begin
		dec_nxt = '0;
		dec_nxt.valid = instr_valid_i;
		dec_nxt.len = instr_len(opcode_i);
		dec_nxt.flag_act = flag_action(opcode_i);
		dec_nxt.is_move = (opcode_i[7:4] inside {4'h7, 4'hE, 4'hF}) ||
			(opcode_i[7:4] == 4'hA && opcode_i[3:0] >= 4'h6) ||
			(opcode_i[7:4] == 4'h8 && opcode_i[3:0] >= 4'h5) ||
			(opcode_i inside {8'h83, 8'h90, 8'h92, 8'h93, 8'hA2});
		if (opcode_i[3:0] >= 4'h4 && (opcode_i[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9})) begin
			dec_nxt.dst_mode = cadf_pkg::CADF_AM_REG;
			dec_nxt.src_mode = operand_mode(opcode_i[3:0]);
		end else if ((opcode_i[7:4] inside {4'h4, 4'h5, 4'h6}) && (opcode_i[3:1] == 3'h1)) begin
			dec_nxt.dst_mode = cadf_pkg::CADF_AM_DIRECT;
			dec_nxt.src_mode = opcode_i[0] ? cadf_pkg::CADF_AM_IMMEDIATE : cadf_pkg::CADF_AM_REG;
		end else if ((opcode_i[7:4] inside {4'h0, 4'h1}) && opcode_i[3:0] >= 4'h4) begin
			dec_nxt.dst_mode = (opcode_i[3:0] == 4'h4) ? cadf_pkg::CADF_AM_REG :
				operand_mode(opcode_i[3:0]);
		end else if (opcode_i[7:4] == 4'hE && opcode_i[3:0] >= 4'h4) begin
			dec_nxt.dst_mode = cadf_pkg::CADF_AM_REG;
			dec_nxt.src_mode = (opcode_i[3:0] == 4'h4) ? cadf_pkg::CADF_AM_NONE :
				operand_mode(opcode_i[3:0]);
		end else if (opcode_i[7:4] == 4'hF && opcode_i[3:0] >= 4'h5) begin
			dec_nxt.dst_mode = operand_mode(opcode_i[3:0]);
			dec_nxt.src_mode = cadf_pkg::CADF_AM_REG;
		end else if (opcode_i == 8'h74) begin
			dec_nxt.dst_mode = cadf_pkg::CADF_AM_REG;
			dec_nxt.src_mode = cadf_pkg::CADF_AM_IMMEDIATE;
		end else if (opcode_i == `CADF_OP_LOAD_DP) begin
			dec_nxt.dst_mode = cadf_pkg::CADF_AM_REG;
			dec_nxt.src_mode = cadf_pkg::CADF_AM_IMMEDIATE;
		end else if (opcode_i == `CADF_OP_MOVC_PC || opcode_i == `CADF_OP_MOVC_DP) begin
			dec_nxt.dst_mode = cadf_pkg::CADF_AM_REG;
			dec_nxt.src_mode = cadf_pkg::CADF_AM_BASED;
		end else if (opcode_i == `CADF_OP_PUSH || opcode_i == `CADF_OP_POP) begin
			dec_nxt.dst_mode = cadf_pkg::CADF_AM_INDIRECT;
			dec_nxt.src_mode = cadf_pkg::CADF_AM_DIRECT;
		end
		// Immediate and based forms only ever land in src_mode above
		dec_nxt.rmw = !dec_nxt.is_move && dec_nxt.dst_mode != cadf_pkg::CADF_AM_NONE &&
			dec_nxt.src_mode != cadf_pkg::CADF_AM_NONE;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dec_r <= '0;
		end else begin
			dec_r <= dec_nxt;
		end
	end

	// Address group
	always_comb begin
		ri_val = opcode_i[0] ? working_register_1_i : working_register_0_i;
		addr_nxt = '0;
		addr_nxt.reg_addr = {3'h0, stat_r[`CADF_RS_HI:`CADF_RS_LO], opcode_i[2:0]};
		addr_nxt.direct_addr = operand1_i;
		addr_nxt.direct_is_sfr = operand1_i >= `CADF_SFR_BASE;
		addr_nxt.bit_pos = operand1_i[2:0];
		if (operand1_i[7])
			addr_nxt.bit_byte = {operand1_i[7:3], 3'h0};
		else
			addr_nxt.bit_byte = `CADF_BIT_RAM_BASE + {4'h0, operand1_i[6:3]};
		if (opcode_i == `CADF_OP_PUSH || opcode_i == `CADF_OP_POP)
			addr_nxt.iram_ind = stack_pointer_i;
		else
			addr_nxt.iram_ind = ri_val;
		if (opcode_i == `CADF_OP_MOVX_DP_RD || opcode_i == `CADF_OP_MOVX_DP_WR)
			addr_nxt.aux_addr = data_pointer_i;
		else
			addr_nxt.aux_addr = {8'h00, ri_val};
		if (opcode_i == `CADF_OP_LOAD_DP)
			addr_nxt.imm = {operand1_i, operand2_i};
		else
			addr_nxt.imm = {8'h00, operand1_i};
		// Wraps at 64K like the program counter itself
		if (opcode_i == `CADF_OP_MOVC_PC)
			addr_nxt.code_addr = 16'(pc_i + {8'h00, acc_i});
		else
			addr_nxt.code_addr = 16'(data_pointer_i + {8'h00, acc_i});
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_r <= '0;
		end else begin
			addr_r <= addr_nxt;
		end
	end

	// Status word group; instruction flag results win over a same-cycle SFR write
	always_comb begin
		stat_nxt = stat_r;
		stat_bit_hit = sfr_wr_i.bit_we && (sfr_wr_i.bit_addr >= `CADF_STAT_BIT_LO) &&
			(sfr_wr_i.bit_addr <= `CADF_STAT_BIT_HI);
		if (sfr_wr_i.byte_we && sfr_wr_i.byte_addr == `CADF_STAT_ADDR)
			stat_nxt = sfr_wr_i.wdata;
		if (stat_bit_hit)
			stat_nxt[sfr_wr_i.bit_addr[2:0]] = sfr_wr_i.wdata[0];
		if (instr_valid_i) begin
			case (dec_nxt.flag_act)
				cadf_pkg::CADF_FL_ARITH: begin
					stat_nxt[`CADF_CY_POS] = alu_flags_i.carry;
					stat_nxt[`CADF_OVF_POS] = alu_flags_i.overflow;
					stat_nxt[`CADF_HALF_POS] = alu_flags_i.half_carry;
				end
				cadf_pkg::CADF_FL_MULDIV: begin
					stat_nxt[`CADF_CY_POS] = 1'b0;
					stat_nxt[`CADF_OVF_POS] = alu_flags_i.overflow;
				end
				cadf_pkg::CADF_FL_DEC_ADJ: begin
					stat_nxt[`CADF_CY_POS] = alu_flags_i.carry;
					stat_nxt[`CADF_OVF_POS] = alu_flags_i.overflow;
				end
				cadf_pkg::CADF_FL_CARRY: stat_nxt[`CADF_CY_POS] = alu_flags_i.carry;
				cadf_pkg::CADF_FL_SET_C: stat_nxt[`CADF_CY_POS] = 1'b1;
				cadf_pkg::CADF_FL_CLR_C: stat_nxt[`CADF_CY_POS] = 1'b0;
				default: stat_nxt = stat_nxt;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stat_r <= `CADF_STAT_RESET;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	assign dec_o = dec_r;
	assign addr_o = addr_r;
	assign program_status_word_o = stat_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence seq_issue(logic [7:0] op);
		instr_valid_i && opcode_i == op;
	endsequence

	sequence seq_quiet_sfr;
		!sfr_wr_i.byte_we && !sfr_wr_i.bit_we;
	endsequence

	long_jump_len_a: assert property (seq_issue(8'h02) |=> dec_o.len == 2'h3)
		else $error("three-byte opcode not decoded as length 3");
	short_len_a: assert property (seq_issue(8'h24) |=> dec_o.len == 2'h2 && dec_o.valid)
		else $error("two-byte opcode not decoded as length 2");
	write_back_a: assert property (seq_issue(8'h28) |=> dec_o.rmw && !dec_o.is_move)
		else $error("register add lacks write-back to destination");
	bank_select_a: assert property (instr_valid_i && opcode_i[3] |=>
		addr_o.reg_addr == {3'h0, $past(stat_r[4:3]), $past(opcode_i[2:0])})
		else $error("working register address ignores bank");
	direct_space_a: assert property (instr_valid_i |=>
		addr_o.direct_is_sfr == $past(operand1_i[7]) && addr_o.direct_addr == $past(operand1_i))
		else $error("direct address split wrong");
	bit_ram_a: assert property (instr_valid_i && !operand1_i[7] |=>
		addr_o.bit_byte == 8'(8'h20 + $past(operand1_i[6:3])))
		else $error("RAM bit byte wrong");
	stack_ind_a: assert property (seq_issue(8'hC0) |=> addr_o.iram_ind == $past(stack_pointer_i))
		else $error("push does not address by stack pointer");
	aux_pointer_a: assert property (seq_issue(8'hE0) |=> addr_o.aux_addr == $past(data_pointer_i))
		else $error("aux access not using data pointer");
	imm_wide_a: assert property (seq_issue(8'h90) |=>
		addr_o.imm == {$past(operand1_i), $past(operand2_i)})
		else $error("16-bit immediate wrong");
	based_pc_a: assert property (seq_issue(8'h83) |=>
		addr_o.code_addr == 16'($past(pc_i) + {8'h00, $past(acc_i)}))
		else $error("pc-based table address wrong");
	dst_legal_a: assert property (dec_o.valid |->
		!(dec_o.dst_mode inside {cadf_pkg::CADF_AM_IMMEDIATE, cadf_pkg::CADF_AM_BASED}))
		else $error("illegal destination mode");
	move_no_rmw_a: assert property (seq_issue(8'h93) |=> dec_o.is_move && !dec_o.rmw)
		else $error("move marked as read-modify-write");
	arith_flags_a: assert property (seq_issue(8'h94) |=>
		stat_r[7] == $past(alu_flags_i.carry) && stat_r[6] == $past(alu_flags_i.half_carry)
		&& stat_r[2] == $past(alu_flags_i.overflow))
		else $error("subtract flags not taken");
	// A same-cycle byte write may legally move the half carry, so keep it out
	muldiv_carry_a: assert property (seq_issue(8'hA4) ##0 seq_quiet_sfr |=>
		!stat_r[7] && stat_r[2] == $past(alu_flags_i.overflow) && $stable(stat_r[6]))
		else $error("multiply flag result wrong");
	dec_adj_a: assert property (seq_issue(8'hD4) |=>
		stat_r[7] == $past(alu_flags_i.carry) && stat_r[2] == $past(alu_flags_i.overflow))
		else $error("decimal adjust flags not taken");
	set_carry_a: assert property (seq_issue(8'hD3) ##0 seq_quiet_sfr |=>
		stat_r[7] && stat_r[6:0] == $past(stat_r[6:0]))
		else $error("set carry disturbed other bits");
	clr_carry_a: assert property (seq_issue(8'hC3) ##0 seq_quiet_sfr |=>
		!stat_r[7] && stat_r[6:0] == $past(stat_r[6:0]))
		else $error("clear carry disturbed other bits");
	carry_only_a: assert property (seq_issue(8'h33) ##0 seq_quiet_sfr |=>
		stat_r[7] == $past(alu_flags_i.carry) && stat_r[6:0] == $past(stat_r[6:0]))
		else $error("rotate through carry touched other flags");
	stat_byte_a: assert property (!instr_valid_i && sfr_wr_i.byte_we && sfr_wr_i.byte_addr == 8'hD0
		&& !sfr_wr_i.bit_we |=> stat_r == $past(sfr_wr_i.wdata))
		else $error("status word byte write lost");
	stat_bit_a: assert property (!instr_valid_i && !sfr_wr_i.byte_we && sfr_wr_i.bit_we
		&& sfr_wr_i.bit_addr == 8'hD2 |=> stat_r[2] == $past(sfr_wr_i.wdata[0]))
		else $error("overflow bit write lost");

endmodule

// file: hdl/cadf_defines.svh
// Constants of the instruction decoder: addresses, field positions, reset values.
// Assumes the includer wraps nothing around these; definitions only.
`ifndef CADF_DEFINES_SVH
`define CADF_DEFINES_SVH

`define CADF_LEN_ONE_COUNT 49
`define CADF_LEN_TWO_COUNT 45
`define CADF_LEN_THREE_COUNT 17
`define CADF_BANK_COUNT 4
`define CADF_SFR_BASE 8'h80
`define CADF_BIT_RAM_BASE 8'h20
`define CADF_STAT_ADDR 8'hD0
`define CADF_STAT_BIT_LO 8'hD1
`define CADF_STAT_BIT_HI 8'hD7
`define CADF_STAT_RESET 8'h00
`define CADF_CY_POS 7
`define CADF_HALF_POS 6
`define CADF_RS_HI 4
`define CADF_RS_LO 3
`define CADF_OVF_POS 2
`define CADF_OP_PUSH 8'hC0
`define CADF_OP_POP 8'hD0
`define CADF_OP_MOVX_DP_RD 8'hE0
`define CADF_OP_MOVX_DP_WR 8'hF0
`define CADF_OP_MOVC_PC 8'h83
`define CADF_OP_MOVC_DP 8'h93
`define CADF_OP_LOAD_DP 8'h90
`define CADF_OP_MUL 8'hA4
`define CADF_OP_DIV 8'h84
`define CADF_OP_DEC_ADJ 8'hD4
`define CADF_OP_SET_C 8'hD3
`define CADF_OP_CLR_C 8'hC3

`endif

// file: hdl/cadf_pkg.sv
// Types shared by the instruction decoder and its surroundings.
// Assumes cadf_defines.svh supplies the numeric constants.
package cadf_pkg;

	typedef enum logic [2:0] {
		CADF_AM_NONE,
		CADF_AM_REG,
		CADF_AM_DIRECT,
		CADF_AM_INDIRECT,
		CADF_AM_IMMEDIATE,
		CADF_AM_BASED
	} cadf_mode_t;

	typedef enum logic [2:0] {
		CADF_FL_NONE,
		CADF_FL_ARITH,
		CADF_FL_MULDIV,
		CADF_FL_DEC_ADJ,
		CADF_FL_CARRY,
		CADF_FL_SET_C,
		CADF_FL_CLR_C
	} cadf_flag_act_t;

	typedef struct packed {
		logic valid;
		logic [1:0] len;
		cadf_mode_t dst_mode;
		cadf_mode_t src_mode;
		logic is_move;
		logic rmw;
		cadf_flag_act_t flag_act;
	} cadf_decode_t;

	typedef struct packed {
		logic [7:0] reg_addr;
		logic [7:0] direct_addr;
		logic direct_is_sfr;
		logic [7:0] bit_byte;
		logic [2:0] bit_pos;
		logic [7:0] iram_ind;
		logic [15:0] aux_addr;
		logic [15:0] imm;
		logic [15:0] code_addr;
	} cadf_addr_t;

	typedef struct packed {
		logic carry;
		logic overflow;
		logic half_carry;
	} cadf_alu_flags_t;

	typedef struct packed {
		logic byte_we;
		logic [7:0] byte_addr;
		logic bit_we;
		logic [7:0] bit_addr;
		logic [7:0] wdata;
	} cadf_sfr_wr_t;

endpackage

// file: testbench/cadf_code_mem.sv
// Program memory model: hands the decoder the bytes stored at the fetch address.
// Assumes the bench loads bytes through put before it presents that address.
`timescale 1ns/1ps
module cadf_code_mem (
	input wire logic [15:0] addr_i,
	output logic [7:0] opcode_o,
	output logic [7:0] operand1_o,
	output logic [7:0] operand2_o
);
	logic [7:0] mem [0:255];

	// Unloaded bytes differ from their neighbours, so a stale byte is never mistaken
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'hA5;
		end
	end

	assign opcode_o = mem[addr_i[7:0]];
	assign operand1_o = mem[8'(addr_i[7:0] + 8'h01)];
	assign operand2_o = mem[8'(addr_i[7:0] + 8'h02)];

	task automatic put(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b2);
		mem[a] = b0;
		mem[8'(a + 8'h01)] = b1;
		mem[8'(a + 8'h02)] = b2;
	endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the instruction decoder, bytes fetched from a code model.
// Assumes the decoder registers every result one clock after its inputs.
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [7:0] op, o1, o2, acc = 8'h10, stk_val = 8'h55, ri0_val = 8'h33, ri1_val = 8'h44;
	logic [15:0] pc = 16'h0000, dp_val = 16'h1234;
	cadf_pkg::cadf_alu_flags_t alu = '0;
	cadf_pkg::cadf_sfr_wr_t sfr = '0;
	cadf_pkg::cadf_decode_t dec;
	cadf_pkg::cadf_addr_t ad;
	logic [7:0] stat_word;
	int n_fail = 0;
	int n_checks = 0;

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	cadf_code_mem mem (.addr_i(pc), .opcode_o(op), .operand1_o(o1), .operand2_o(o2));

	cadf_decoder dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
		.opcode_i(op), .operand1_i(o1), .operand2_i(o2), .acc_i(acc),
		.data_pointer_i(dp_val), .pc_i(pc), .stack_pointer_i(stk_val),
		.working_register_0_i(ri0_val), .working_register_1_i(ri1_val), .alu_flags_i(alu),
		.sfr_wr_i(sfr), .dec_o(dec), .addr_o(ad), .program_status_word_o(stat_word));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One idle cycle first, so valid never drops and rises in one time step
	task automatic instr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		@(negedge clk_i);
		pc = pc + 16'h0003;
		mem.put(pc[7:0], b0, b1, b2);
		instr_valid_i = 1'b1;
		@(negedge clk_i);
		instr_valid_i = 1'b0;
	endtask

	task automatic wr(input logic bw, input logic [7:0] ba, input logic tw, input logic [7:0] ta,
			input logic [7:0] d);
		@(negedge clk_i);
		sfr = '{byte_we: bw, byte_addr: ba, bit_we: tw, bit_addr: ta, wdata: d};
		@(negedge clk_i);
		sfr = '0;
	endtask

	task automatic t_arith();
		alu = '{carry: 1'b1, overflow: 1'b1, half_carry: 1'b1};
		instr(8'h24, 8'h05, 8'h00);
		chk("valid", 16'd1, 16'(dec.valid));
		chk("len add", 16'd2, 16'(dec.len));
		chk("rmw", 16'd1, 16'(dec.rmw));
		chk("dst add", 16'(cadf_pkg::CADF_AM_REG), 16'(dec.dst_mode));
		chk("imm8", 16'h0005, ad.imm);
		chk("flag add", 16'(cadf_pkg::CADF_FL_ARITH), 16'(dec.flag_act));
		chk("stat add", 16'h00C4, 16'(stat_word));
		alu = '0;
		instr(8'h95, 8'h20, 8'h00);
		chk("stat sub", 16'h0000, 16'(stat_word));
	endtask

	task automatic t_carry();
		instr(8'hD3, 8'h00, 8'h00);
		chk("stat set c", 16'h0080, 16'(stat_word));
		instr(8'hC3, 8'h00, 8'h00);
		chk("stat clr c", 16'h0000, 16'(stat_word));
		wr(1'b1, 8'hD0, 1'b0, 8'h00, 8'h44);
		alu = '{carry: 1'b1, overflow: 1'b0, half_carry: 1'b0};
		instr(8'h13, 8'h00, 8'h00);
		chk("stat rotate", 16'h00C4, 16'(stat_word));
	endtask

	task automatic t_muldiv();
		alu = '{carry: 1'b1, overflow: 1'b1, half_carry: 1'b0};
		instr(8'hA4, 8'h00, 8'h00);
		chk("len mul", 16'd1, 16'(dec.len));
		chk("stat mul", 16'h0044, 16'(stat_word));
		alu = '{carry: 1'b1, overflow: 1'b0, half_carry: 1'b1};
		instr(8'h84, 8'h00, 8'h00);
		chk("stat div", 16'h0040, 16'(stat_word));
		alu = '{carry: 1'b1, overflow: 1'b1, half_carry: 1'b0};
		instr(8'hD4, 8'h00, 8'h00);
		chk("stat adjust", 16'h00C4, 16'(stat_word));
	endtask

	task automatic t_status();
		wr(1'b1, 8'hD0, 1'b0, 8'h00, 8'h18);
		chk("stat byte", 16'h0018, 16'(stat_word));
		wr(1'b0, 8'h00, 1'b1, 8'hD7, 8'h01);
		chk("stat bit7", 16'h0098, 16'(stat_word));
		wr(1'b0, 8'h00, 1'b1, 8'hD2, 8'h01);
		chk("stat bit2", 16'h009C, 16'(stat_word));
		wr(1'b1, 8'hD1, 1'b1, 8'hD0, 8'hFF);
		chk("stat other", 16'h009C, 16'(stat_word));
		instr(8'hE9, 8'h00, 8'h00);
		chk("bank reg", 16'h0019, 16'(ad.reg_addr));
	endtask

	task automatic t_direct();
		instr(8'h25, 8'h90, 8'h00);
		chk("dir sfr", 16'h0190, {7'h00, ad.direct_is_sfr, ad.direct_addr});
		instr(8'h25, 8'h7F, 8'h00);
		chk("dir ram", 16'h007F, {7'h00, ad.direct_is_sfr, ad.direct_addr});
		instr(8'hD2, 8'h0A, 8'h00);
		chk("bit ram", 16'h0221, {5'h00, ad.bit_pos, ad.bit_byte});
		instr(8'hD2, 8'hD3, 8'h00);
		chk("bit sfr", 16'h03D0, {5'h00, ad.bit_pos, ad.bit_byte});
	endtask

	task automatic t_indirect();
		instr(8'h26, 8'h00, 8'h00);
		chk("ind reg0", 16'h0033, 16'(ad.iram_ind));
		instr(8'h27, 8'h00, 8'h00);
		chk("ind reg1", 16'h0044, 16'(ad.iram_ind));
		instr(8'hC0, 8'h30, 8'h00);
		chk("ind stack", 16'h0055, 16'(ad.iram_ind));
		instr(8'hE0, 8'h00, 8'h00);
		chk("aux dp", 16'h1234, ad.aux_addr);
		instr(8'hE3, 8'h00, 8'h00);
		chk("aux reg1", 16'h0044, ad.aux_addr);
	endtask

	task automatic t_based();
		instr(8'h93, 8'h00, 8'h00);
		chk("base dp", 16'h1244, ad.code_addr);
		chk("src based", 16'(cadf_pkg::CADF_AM_BASED), 16'(dec.src_mode));
		chk("move based", 16'd1, 16'(dec.is_move));
		chk("rmw move", 16'd0, 16'(dec.rmw));
		instr(8'h83, 8'h00, 8'h00);
		chk("base pc", pc + 16'h0010, ad.code_addr);
		instr(8'h90, 8'hAB, 8'hCD);
		chk("imm16", 16'hABCD, ad.imm);
		chk("len load dp", 16'd3, 16'(dec.len));
	endtask

	initial begin
		repeat (2000) @(posedge clk_i);
		n_fail++;
		finish_test();
	end

	initial begin
		repeat (20) @(negedge clk_i);
		chk("stat reset", 16'h0000, 16'(stat_word));
		reset_n_i = 1'b1;
		@(negedge clk_i);
		t_arith();
		t_carry();
		t_muldiv();
		t_status();
		t_direct();
		t_indirect();
		t_based();
		finish_test();
	end
endmodule
